// ### flash_security_protection_pkg.sv
/*
  constants and carrier types for the flash security and protection control.
  assumes one 100 MHz clock domain and a serial command bus sampled on that clock.
*/
package flash_security_protection_pkg;
  // ****************************************
  // command bytes
  // ****************************************
  localparam logic [7:0] SET_WRITE_LATCH_CMD    = 8'h10;
  localparam logic [7:0] ENTER_OTP_CMD          = 8'h11;
  localparam logic [7:0] EXIT_OTP_CMD           = 8'h12;
  localparam logic [7:0] READ_SECURITY_REG_CMD  = 8'h13;
  localparam logic [7:0] WRITE_SECURITY_REG_CMD = 8'h14;
  localparam logic [7:0] PROTECT_SELECT_CMD     = 8'h15;
  localparam logic [7:0] WRITE_LOCK_REG_CMD     = 8'h16;
  localparam logic [7:0] READ_LOCK_REG_CMD      = 8'h17;
  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int SEC_FACTORY_BIT  = 0;
  localparam int SEC_LOCKDOWN_BIT = 1;
  localparam int SEC_PSUSP_BIT    = 2;
  localparam int SEC_ESUSP_BIT    = 3;
  localparam int SEC_PFAIL_BIT    = 5;
  localparam int SEC_EFAIL_BIT    = 6;
  localparam int SEC_SCHEME_BIT   = 7;
  localparam int LOCK_SOLID_BIT   = 1;
  localparam int LOCK_PASS_BIT    = 2;
  localparam logic [15:0] LOCK_RESET = 16'hFFFF;
  localparam int ADDR_W       = 26;
  localparam int UNIT_W       = 12;
  localparam int EDGE_UNIT_KB = 64;
  localparam logic [UNIT_W-1:0] TOP_SECTOR_BASE = 12'h010;
  localparam logic [UNIT_W-1:0] MID_BLOCK_BASE  = 12'h020;
  // ****************************************
  // carrier types
  // ****************************************
  typedef enum logic [1:0] {FR_IDLE, FR_CMD, FR_DATA, FR_READ} frame_state_type;
  typedef struct packed {
    logic prog_done;
    logic prog_ok;
    logic erase_done;
    logic erase_ok;
    logic prog_suspend;
    logic prog_resume;
    logic erase_suspend;
    logic erase_resume;
  } array_event_type;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [3:0]        block_protect_bits;
    logic              bp_hit;
    logic              solid;
    logic              dynamic;
  } protect_query_type;
endpackage

// ### flash_security_protection_ctl.sv
/*
  security status, protection scheme select and otp lock register of a serial
  flash, with its command front end. assumes the array engine reports events
  and looks up solid/dynamic bits for the unit index given here.
*/
// Behaviour
// - exit-otp command leaves secured otp mode
// - opcode: eight single-line or two quad clocks
// - security register readable anytime, repeats out
// - lockdown bit only settable, then frozen
// - write rejected unless chip-select ends on byte
// - erase fail set on failure, cleared on success
// - program fail set on failure, cleared on success
// - erase suspended flag follows suspend and resume
// - program suspended flag follows suspend and resume
// - bit0 shows factory otp lock
// - scheme 0 uses block-protect bits, 1 sectors
// - protect select sets scheme bit permanently
// - sector mode enables commands, dynamic bits set; here dynamic_preset pulses only after reset, not on scheme select
// - write-protect pin low blocks all writes in sector scheme only
// - sector/block protected by solid or dynamic, mask
// - solid changes need password in password mode
// - 16-bit lock register, bits 2:1 pick flavour
// - lock write clears bit1 or bit2 permanently
// - clearing several bits aborts, sets program fail
// - once a mode bit cleared, other frozen
// - otp mode denies main array access
`timescale 1ns/1ns
module flash_security_protection_ctl
  import flash_security_protection_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              ce,
  input  wire logic              cs_n,
  input  wire logic              sclk,
  input  wire logic [3:0]        sio_in,
  input  wire logic              quad_command_mode,
  input  wire logic              wp_n,
  input  wire logic              factory_lock,
  input  wire logic              password_ok,
  input  wire logic              solid_mask_bit,
  input  wire array_event_type   evt,
  input  wire protect_query_type query,
  output logic [3:0]             sio_out,
  output logic [3:0]             sio_oe,
  output logic                   otp_mode,
  output logic                   write_latch_flag,
  output logic [7:0]             security_status,
  output logic [15:0]            protection_lock,
  output logic                   sector_cmds_enabled,
  output logic                   dynamic_preset,
  output logic                   solid_change_ok,
  output logic                   write_allowed,
  output logic                   main_array_ok,
  output logic [UNIT_W-1:0]      prot_unit,
  output logic                   unit_is_sector
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [2:0] sclk_r;
  logic [1:0] cs_r;
  logic [1:0] wp_r;
  logic [3:0] sio1_r;
  logic [3:0] sio2_r;
  logic       cs_prev_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_r    <= 3'h0;
      cs_r      <= 2'h3;
      wp_r      <= 2'h3;
      sio1_r    <= 4'h0;
      sio2_r    <= 4'h0;
      cs_prev_r <= 1'b1;
    end else if (ce) begin
      sclk_r    <= {sclk_r[1:0], sclk};
      cs_r      <= {cs_r[0], cs_n};
      wp_r      <= {wp_r[0], wp_n};
      sio1_r    <= sio_in;
      sio2_r    <= sio1_r;
      cs_prev_r <= cs_r[1];
    end
  end

  // edges are taken from the second and third stages only
  wire rise_w     = sclk_r[1] & ~sclk_r[2] & ~cs_r[1];
  wire fall_w     = ~sclk_r[1] & sclk_r[2] & ~cs_r[1];
  wire cs_start_w = cs_prev_r & ~cs_r[1];
  wire cs_end_w   = ~cs_prev_r & cs_r[1];
  wire wp_low_w   = ~wp_r[1];

  // ****************************************
  // command shifter
  // ****************************************
  frame_state_type fr_state_r;
  frame_state_type fr_state_nxt;
  logic [2:0]  bitpos_r;
  logic [1:0]  bytes_r;
  logic [15:0] in_sh_r;
  logic [7:0]  op_r;
  logic [3:0]  out_pos_r;

  wire [2:0]  step_w      = quad_command_mode ? 3'h4 : 3'h1;
  wire [2:0]  bitpos_nxt  = bitpos_r + step_w;
  wire        byte_done_w = rise_w & (bitpos_nxt == 3'h0);
  // upper lines are ignored in single-line mode
  wire [15:0] in_sh_nxt   = quad_command_mode ? {in_sh_r[11:0], sio2_r}
                                              : {in_sh_r[14:0], sio2_r[0]};
  wire        is_read_w   = (in_sh_nxt[7:0] == READ_SECURITY_REG_CMD) |
                            (in_sh_nxt[7:0] == READ_LOCK_REG_CMD);
  wire        boundary_w  = (bitpos_r == 3'h0) & (bytes_r != 2'h0);

  always_comb begin
    fr_state_nxt = fr_state_r;
    case (fr_state_r)
      FR_IDLE: if (cs_start_w) fr_state_nxt = FR_CMD;
      FR_CMD: begin
        if (cs_end_w) fr_state_nxt = FR_IDLE;
        else if (byte_done_w) fr_state_nxt = is_read_w ? FR_READ : FR_DATA;
      end
      FR_DATA: if (cs_end_w) fr_state_nxt = FR_IDLE;
      FR_READ: if (cs_end_w) fr_state_nxt = FR_IDLE;
      default: fr_state_nxt = FR_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fr_state_r <= FR_IDLE;
      bitpos_r   <= 3'h0;
      bytes_r    <= 2'h0;
      in_sh_r    <= 16'h0000;
      op_r       <= 8'h00;
    end else if (ce) begin
      fr_state_r <= fr_state_nxt;
      if (cs_start_w) begin
        bitpos_r <= 3'h0;
        bytes_r  <= 2'h0;
      end else if (rise_w) begin
        bitpos_r <= bitpos_nxt;
        in_sh_r  <= in_sh_nxt;
        if (byte_done_w && bytes_r != 2'h3) bytes_r <= bytes_r + 2'h1;
        if (byte_done_w && fr_state_r == FR_CMD) op_r <= in_sh_nxt[7:0];
      end
    end
  end

  // ****************************************
  // command execution at chip-select rise
  // ****************************************
  wire exec_w      = cs_end_w & (fr_state_r == FR_DATA) & boundary_w;
  wire do_set_write_latch_cmd_w   = exec_w & (op_r == SET_WRITE_LATCH_CMD);
  wire do_enter_w  = exec_w & (op_r == ENTER_OTP_CMD);
  wire do_exit_w   = exec_w & (op_r == EXIT_OTP_CMD);
  wire do_write_security_reg_cmd_w = exec_w & (op_r == WRITE_SECURITY_REG_CMD) & write_latch_flag;
  wire do_select_w = exec_w & (op_r == PROTECT_SELECT_CMD) & write_latch_flag;
  // lock write carries two data bytes, high byte first
  wire do_lock_w   = exec_w & (op_r == WRITE_LOCK_REG_CMD) & (bytes_r == 2'h3) &
                     write_latch_flag & security_status[SEC_SCHEME_BIT];

  wire [15:0] clr_w       = protection_lock & ~in_sh_r;
  wire [15:0] clr_less_w  = clr_w - 16'h0001;
  wire        multi_w     = |(clr_w & clr_less_w);
  wire        both_w      = clr_w[LOCK_SOLID_BIT] & clr_w[LOCK_PASS_BIT];
  wire        mode_fixed_w = ~protection_lock[LOCK_SOLID_BIT] |
                             ~protection_lock[LOCK_PASS_BIT];
  wire        other_w     = mode_fixed_w & (clr_w[LOCK_SOLID_BIT] | clr_w[LOCK_PASS_BIT]);
  wire        lock_abort_w = do_lock_w & (multi_w | both_w);
  wire        lock_ok_w   = do_lock_w & ~multi_w & ~both_w & ~other_w;

  // ****************************************
  // security status register
  // ****************************************
  logic otp_lockdown_flag_r;
  logic scheme_r;
  logic factory_r;
  logic pfail_r;
  logic efail_r;
  logic psusp_r;
  logic esusp_r;

  // set wins over clear on every hardware flag
  wire pfail_set_w = (evt.prog_done & ~evt.prog_ok) | lock_abort_w;
  wire efail_set_w = evt.erase_done & ~evt.erase_ok;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      otp_lockdown_flag_r    <= 1'b0;
      scheme_r  <= 1'b0;
      factory_r <= 1'b0;
      pfail_r   <= 1'b0;
      efail_r   <= 1'b0;
      psusp_r   <= 1'b0;
      esusp_r   <= 1'b0;
    end else if (ce) begin
      factory_r <= factory_lock;
      if (do_write_security_reg_cmd_w) otp_lockdown_flag_r <= 1'b1;
      if (do_select_w) scheme_r <= 1'b1;
      if (pfail_set_w) pfail_r <= 1'b1;
      else if (evt.prog_done) pfail_r <= 1'b0;
      if (efail_set_w) efail_r <= 1'b1;
      else if (evt.erase_done) efail_r <= 1'b0;
      if (evt.prog_suspend) psusp_r <= 1'b1;
      else if (evt.prog_resume) psusp_r <= 1'b0;
      if (evt.erase_suspend) esusp_r <= 1'b1;
      else if (evt.erase_resume) esusp_r <= 1'b0;
    end
  end

  always_comb begin
    security_status = 8'h00;
    security_status[SEC_FACTORY_BIT]  = factory_r;
    security_status[SEC_LOCKDOWN_BIT] = otp_lockdown_flag_r;
    security_status[SEC_PSUSP_BIT]    = psusp_r;
    security_status[SEC_ESUSP_BIT]    = esusp_r;
    security_status[SEC_PFAIL_BIT]    = pfail_r;
    security_status[SEC_EFAIL_BIT]    = efail_r;
    security_status[SEC_SCHEME_BIT]   = scheme_r;
  end

  // ****************************************
  // lock register, latch, otp mode
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      protection_lock  <= LOCK_RESET;
      write_latch_flag <= 1'b0;
      otp_mode         <= 1'b0;
    end else if (ce) begin
      if (lock_ok_w) protection_lock <= protection_lock & ~clr_w;
      if (do_set_write_latch_cmd_w) write_latch_flag <= 1'b1;
      else if (do_write_security_reg_cmd_w || do_select_w || do_lock_w) write_latch_flag <= 1'b0;
      if (do_enter_w) otp_mode <= 1'b1;
      else if (do_exit_w) otp_mode <= 1'b0;
    end
  end

  // ****************************************
  // read-out on falling serial clock
  // ****************************************
  wire [15:0] rd_word_w = (op_r == READ_LOCK_REG_CMD) ? protection_lock
                                                      : {security_status, security_status};
  wire [15:0] rd_sh_w   = rd_word_w << out_pos_r;
  wire        reading_w = fall_w & (fr_state_r == FR_READ);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_pos_r <= 4'h0;
      sio_out   <= 4'h0;
      sio_oe    <= 4'h0;
    end else if (ce) begin
      if (fr_state_r != FR_READ) begin
        out_pos_r <= 4'h0;
        sio_oe    <= 4'h0;
      end else if (reading_w) begin
        // the word wraps, so the value streams out until chip-select rises
        out_pos_r <= out_pos_r + {1'b0, step_w};
        sio_out   <= quad_command_mode ? rd_sh_w[15:12] : {2'h0, rd_sh_w[15], 1'b0};
        sio_oe    <= quad_command_mode ? 4'hF : 4'h2;
      end
    end
  end

  // ****************************************
  // protection decision
  // ****************************************
  wire lo_w = (query.addr[ADDR_W-1:16] == '0);
  wire hi_w = (query.addr[ADDR_W-1:16] == '1);
  wire [UNIT_W-1:0] sect_w = UNIT_W'(query.addr[15:12]);
  wire [UNIT_W-1:0] unit_nxt = lo_w ? sect_w :
                               hi_w ? sect_w + TOP_SECTOR_BASE :
                               UNIT_W'(query.addr[ADDR_W-1:16]) + MID_BLOCK_BASE;
  // a cleared mask hides the solid bits
  wire solid_eff_w = query.solid & solid_mask_bit;
  wire bp_prot_w   = (|query.block_protect_bits) & query.bp_hit;
  wire sec_prot_w  = wp_low_w | solid_eff_w | query.dynamic;
  wire prot_w      = scheme_r ? sec_prot_w : bp_prot_w;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prot_unit           <= '0;
      unit_is_sector      <= 1'b0;
      write_allowed       <= 1'b0;
      main_array_ok       <= 1'b0;
      sector_cmds_enabled <= 1'b0;
      dynamic_preset      <= 1'b1;
      solid_change_ok     <= 1'b0;
    end else if (ce) begin
      prot_unit           <= unit_nxt;
      unit_is_sector      <= lo_w | hi_w;
      write_allowed       <= ~prot_w & ~otp_mode;
      main_array_ok       <= ~otp_mode;
      sector_cmds_enabled <= scheme_r;
      // one pulse after reset tells the store to set every dynamic bit
      dynamic_preset      <= 1'b0;
      solid_change_ok     <= scheme_r & (protection_lock[LOCK_PASS_BIT] | password_ok);
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_exit_otp_mode: assert property (ce && do_exit_w |=> !otp_mode)
    else $error("otp mode not left after exit command");
  a_quad_opcode_step: assert property (ce && rise_w && quad_command_mode && !cs_start_w
    |=> bitpos_r == $past(bitpos_r) + 3'h4)
    else $error("quad mode did not take four bits per clock");
  a_read_drives_out: assert property (ce && reading_w |=> sio_oe != 4'h0)
    else $error("read data not driven");
  a_lockdown_sticky: assert property (otp_lockdown_flag_r |=> otp_lockdown_flag_r)
    else $error("lockdown bit cleared");
  a_lockdown_cause: assert property ($rose(otp_lockdown_flag_r) |-> $past(write_latch_flag)
    && $past(boundary_w))
    else $error("lockdown set without latch or off boundary");
  a_efail_set: assert property (ce && efail_set_w |=> efail_r)
    else $error("erase fail flag not set");
  a_pfail_clear: assert property (ce && evt.prog_done && evt.prog_ok && !lock_abort_w
    |=> !pfail_r)
    else $error("program fail not cleared after success");
  a_esusp_track: assert property (ce && evt.erase_suspend |=> esusp_r)
    else $error("erase suspend flag not set");
  a_psusp_track: assert property (ce && evt.prog_resume && !evt.prog_suspend |=> !psusp_r)
    else $error("program suspend flag not cleared");
  a_scheme_sticky: assert property (scheme_r |=> scheme_r)
    else $error("scheme select went back to zero");
  a_wp_blocks_all: assert property (ce && scheme_r && wp_low_w |=> !write_allowed)
    else $error("write allowed with write-protect low");
  a_lock_abort: assert property (ce && lock_abort_w |=> pfail_r
    && protection_lock == $past(protection_lock))
    else $error("bad lock write not aborted");
  a_latch_cleared: assert property (ce && do_lock_w |=> !write_latch_flag)
    else $error("write latch not cleared");

  c_read_stream: cover property (reading_w && out_pos_r == 4'hF);
  c_lockdown: cover property ($rose(otp_lockdown_flag_r));
  c_lock_abort: cover property (lock_abort_w);
  c_scheme_set: cover property ($rose(scheme_r));
endmodule // flash_security_protection_ctl

// ### flash_host_model.sv
/*
  host model: drives chip-select, serial clock and data lines of the flash.
  assumes clk is the device clock; sclk is made from it, 8 clk per period.
*/
`timescale 1ns/1ns
module flash_host_model (
  input  wire logic       clk,
  input  wire logic       quad,
  input  wire logic [3:0] sio_out,
  output logic            cs_n,
  output logic            sclk,
  output logic [3:0]      sio_in
);
  initial begin
    cs_n   = 1'b1;
    sclk   = 1'b0;
    sio_in = 4'h0;
  end
  // ****************************************
  // one sclk period: 4 clk low, 4 clk high
  // ****************************************
  // read data is taken at the end of the high half, so it has settled long since
  task automatic tick(output logic [3:0] smp);
    repeat (4) @(posedge clk);
    #1 sclk = 1'b1;
    repeat (4) @(posedge clk);
    #1 smp = sio_out;
    sclk = 1'b0;
  endtask
  // ****************************************
  // one frame: n units out, then nrd units in
  // ****************************************
  task automatic frame(input logic [23:0] d, input int n, input int nrd,
                       output logic [15:0] rd);
    logic [3:0] s;
    rd = '0;
    @(posedge clk);
    #1 cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      sio_in = quad ? d[i*4+:4] : {sio_in[3:1] ^ 3'h5, d[i]};
      tick(s);
    end
    for (int i = 0; i < nrd; i++) begin
      sio_in = ~sio_in;
      tick(s);
      rd = quad ? {rd[11:0], s} : {rd[14:0], s[1]};
    end
    repeat (4) @(posedge clk);
    #1 cs_n = 1'b1;
    // released lines must not keep showing the last value
    sio_in = ~sio_in;
    repeat (10) @(posedge clk);
  endtask
endmodule // flash_host_model

// ### flash_security_protection_ctl_tb_top.sv
/*
  self-checking bench for the flash security and protection control.
  assumes the host model drives the serial bus and the bench drives the rest.
*/
`timescale 1ns/1ns
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module flash_security_protection_ctl_tb_top
  import flash_security_protection_pkg::*;
;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              ce = 1'b1;
  logic              quad_command_mode = 1'b0;
  logic              wp_n = 1'b1;
  logic              factory_lock = 1'b0;
  logic              password_ok = 1'b0;
  logic              solid_mask_bit = 1'b1;
  array_event_type   evt = '0;
  protect_query_type query = '0;
  logic              cs_n;
  logic              sclk;
  logic [3:0]        sio_in;
  logic [3:0]        sio_out;
  logic [3:0]        sio_oe;
  logic              otp_mode;
  logic              write_latch_flag;
  logic [7:0]        security_status;
  logic [15:0]       protection_lock;
  logic              sector_cmds_enabled;
  logic              dynamic_preset;
  logic              solid_change_ok;
  logic              write_allowed;
  logic              main_array_ok;
  logic [UNIT_W-1:0] prot_unit;
  logic              unit_is_sector;
  int                errors = 0;
  int                comparisons = 0;
  logic [31:0]       seed = 32'h9E8F;
  logic [31:0]       r;
  logic [7:0]        exp_sec;
  logic [15:0]       exp_lock;
  logic [15:0]       rd;
  logic [15:0]       lv [3] = '{16'hFFF9, 16'hFFFD, 16'hFFFB};

  always #5 clk = ~clk;

  flash_host_model i_host (.clk(clk), .quad(quad_command_mode), .sio_out(sio_out),
    .cs_n(cs_n), .sclk(sclk), .sio_in(sio_in));

  flash_security_protection_ctl i_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .cs_n(cs_n),
    .sclk(sclk), .sio_in(sio_in), .quad_command_mode(quad_command_mode), .wp_n(wp_n),
    .factory_lock(factory_lock), .password_ok(password_ok),
    .solid_mask_bit(solid_mask_bit), .evt(evt), .query(query), .sio_out(sio_out),
    .sio_oe(sio_oe), .otp_mode(otp_mode), .write_latch_flag(write_latch_flag),
    .security_status(security_status), .protection_lock(protection_lock),
    .sector_cmds_enabled(sector_cmds_enabled), .dynamic_preset(dynamic_preset),
    .solid_change_ok(solid_change_ok), .write_allowed(write_allowed),
    .main_array_ok(main_array_ok), .prot_unit(prot_unit), .unit_is_sector(unit_is_sector));

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [UNIT_W-1:0] unit_of(input logic [25:0] a);
    if (a[25:16] == 10'h000) return {8'h00, a[15:12]};
    if (a[25:16] == 10'h3FF) return TOP_SECTOR_BASE + {8'h00, a[15:12]};
    return MID_BLOCK_BASE + {2'b00, a[25:16]};
  endfunction

  task automatic cmd(input logic [23:0] d, input int bits);
    i_host.frame(d, quad_command_mode ? bits / 4 : bits, 0, rd);
  endtask

  task automatic evt_chk(input logic [3:0] k);
    array_event_type e;
    e = '0;
    case (k[2:0])
      3'h0: begin e.prog_done = 1'b1; e.prog_ok = k[3]; exp_sec[SEC_PFAIL_BIT] = ~k[3]; end
      3'h1: begin e.erase_done = 1'b1; e.erase_ok = k[3]; exp_sec[SEC_EFAIL_BIT] = ~k[3]; end
      3'h2: begin e.prog_suspend = 1'b1; exp_sec[SEC_PSUSP_BIT] = 1'b1; end
      3'h3: begin e.prog_resume = 1'b1; exp_sec[SEC_PSUSP_BIT] = 1'b0; end
      3'h4: begin e.erase_suspend = 1'b1; exp_sec[SEC_ESUSP_BIT] = 1'b1; end
      default: begin e.erase_resume = 1'b1; exp_sec[SEC_ESUSP_BIT] = 1'b0; end
    endcase
    @(posedge clk);
    #1 evt = e;
    @(posedge clk);
    #1 evt = '0;
    repeat (2) @(posedge clk);
    #1 `CHK("status_event", exp_sec, security_status)
  endtask

  // wp_n is kept high in block mode: only the sector scheme gives it a meaning
  task automatic query_chk(input logic sector);
    logic [31:0] a;
    logic        ew;
    r = xs();
    a = xs();
    if (r[9]) a[25:16] = r[8] ? 10'h3FF : 10'h000;
    else a[25:16] = (a[25:16] & 10'h3FE) | 10'h002;
    @(posedge clk);
    #1 query = '{addr: a[25:0], block_protect_bits: r[3:0], bp_hit: r[4], solid: r[5],
                 dynamic: r[6]};
    wp_n = sector ? r[7] | r[10] : 1'b1;
    solid_mask_bit = r[11];
    password_ok = r[12];
    ew = sector ? (r[7] | r[10]) & ~r[6] & ~(r[5] & r[11]) : ~((|r[3:0]) & r[4]);
    repeat (6) @(posedge clk);
    #1 `CHK("write_allowed", ew, write_allowed)
    `CHK("prot_unit", unit_of(a[25:0]), prot_unit)
    `CHK("unit_is_sector", r[9], unit_is_sector)
    `CHK("solid_change_ok", sector & (exp_lock[2] | r[12]), solid_change_ok)
  endtask

  task automatic test_done();
    if (errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    #500000;
    errors++;
    test_done();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    r = xs();
    factory_lock = r[3];
    repeat (2) @(posedge clk);
    #1 `CHK("preset_in_reset", 1'b1, dynamic_preset)
    rst_n = 1'b1;
    repeat (3) @(posedge clk);
    #1 exp_sec = {7'h00, factory_lock};
    exp_lock = LOCK_RESET;
    `CHK("status_reset", exp_sec, security_status)
    `CHK("lock_reset", exp_lock, protection_lock)
    `CHK("preset_after", 1'b0, dynamic_preset)
    `CHK("otp_ok_latch", 3'b010, {otp_mode, main_array_ok, write_latch_flag})
    for (int q = 0; q < 2; q++) begin
      quad_command_mode = q[0];
      i_host.frame(24'(READ_SECURITY_REG_CMD), q ? 2 : 8, q ? 4 : 16, rd);
      `CHK("status_read", {exp_sec, exp_sec}, rd)
      `CHK("oe_idle", 4'h0, sio_oe)
    end
    quad_command_mode = 1'b0;
    cmd(24'(WRITE_SECURITY_REG_CMD), 8);
    `CHK("status_nolatch", exp_sec, security_status)
    cmd(24'(SET_WRITE_LATCH_CMD), 8);
    `CHK("latch_set", 1'b1, write_latch_flag)
    cmd(24'({WRITE_SECURITY_REG_CMD, 1'b1}), 9);
    `CHK("status_badcut", exp_sec, security_status)
    cmd(24'(SET_WRITE_LATCH_CMD), 8);
    cmd(24'(WRITE_SECURITY_REG_CMD), 8);
    exp_sec[SEC_LOCKDOWN_BIT] = 1'b1;
    `CHK("status_lockdown", exp_sec, security_status)
    `CHK("latch_cleared", 1'b0, write_latch_flag)
    cmd(24'(ENTER_OTP_CMD), 8);
    `CHK("otp_enter", 2'b10, {otp_mode, main_array_ok})
    quad_command_mode = 1'b1;
    cmd(24'(EXIT_OTP_CMD), 8);
    `CHK("otp_exit", 2'b01, {otp_mode, main_array_ok})
    quad_command_mode = 1'b0;
    repeat (40) begin
      r = xs();
      evt_chk(r[3:0]);
    end
    // a suspend pulse while the enable is low must leave the status untouched
    evt_chk(4'h3);
    ce = 1'b0;
    evt.prog_suspend = 1'b1;
    @(posedge clk);
    #1 evt = '0;
    ce = 1'b1;
    repeat (2) @(posedge clk);
    #1 `CHK("status_frozen", exp_sec, security_status)
    repeat (20) query_chk(1'b0);
    cmd(24'(SET_WRITE_LATCH_CMD), 8);
    cmd({WRITE_LOCK_REG_CMD, 16'hFFFD}, 24);
    `CHK("lock_block_mode", exp_lock, protection_lock)
    cmd(24'(SET_WRITE_LATCH_CMD), 8);
    cmd(24'(PROTECT_SELECT_CMD), 8);
    exp_sec[SEC_SCHEME_BIT] = 1'b1;
    `CHK("status_scheme", exp_sec, security_status)
    `CHK("sector_cmds", 1'b1, sector_cmds_enabled)
    repeat (30) query_chk(1'b1);
    evt_chk(4'h8);
    // solid flavour is fixed below, so no password is ever needed
    for (int i = 0; i < 3; i++) begin
      quad_command_mode = (i == 2);
      cmd(24'(SET_WRITE_LATCH_CMD), 8);
      cmd({WRITE_LOCK_REG_CMD, lv[i]}, 24);
      if (i == 0) exp_sec[SEC_PFAIL_BIT] = 1'b1;
      if (i == 1) exp_lock = 16'hFFFD;
      `CHK("lock_write", exp_lock, protection_lock)
      `CHK("status_lock", exp_sec, security_status)
    end
    quad_command_mode = 1'b0;
    repeat (5) query_chk(1'b1);
    test_done();
  end
endmodule // flash_security_protection_ctl_tb_top
